// >>> rtl/dscp_dev.sv
// Converter end: serial control capture, control registers, zero detect.
// Assumes all pins are asynchronous to clk and at least 3 clk wide.
`timescale 1ns/10ps
`default_nettype none
module dscp_dev #(
  parameter int ZERO_RUN = dscp_pkg::ZERO_RUN_BCK
) (
  input  wire logic       clk,
  input  wire logic       reset,
  dscp_if.dev             link,
  input  wire logic       bit_clock_in,
  input  wire logic       frame_clock_in,
  input  wire logic       audio_data_in,
  output logic [8:0]      left_gain_y,
  output logic [8:0]      right_gain_y,
  output logic            soft_mute,
  output logic [1:0]      deemph_sel,
  output logic            bipolar_zero,
  output logic            modulator_connected,
  output logic            i2s_format_sel,
  output logic            word_length_sel,
  output logic            left_frame_active,
  output logic [1:0]      left_route,
  output logic [1:0]      right_route
);

  // Gain numerator y of y/256; code 255 maps to unity.
  function automatic logic [8:0] gain_y(input logic [7:0] code);
    gain_y = (code == dscp_pkg::LEVEL_FULL) ? dscp_pkg::GAIN_UNITY
                                            : {1'b0, code};
  endfunction : gain_y

  logic [6:0]  pins_s;
  logic        mode_s;
  logic        rstn_s;
  logic        mclk_s;
  logic        latch_s;
  logic        data_s;
  logic        bck_s;
  logic        lrc_s;
  logic        din_s;
  logic        mclk_q_reg;
  logic        latch_q_reg;
  logic        bck_q_reg;
  logic        port_en;
  logic        mclk_rise;
  logic        latch_fall;
  logic        bck_rise;
  logic [15:0] shift_reg;
  logic [15:0] left_ctl_reg;
  logic [15:0] right_ctl_reg;
  logic [15:0] mute_ctl_reg;
  logic [15:0] format_ctl_reg;
  logic [7:0]  left_applied_reg;
  logic [7:0]  right_applied_reg;
  logic [16:0] zero_cnt_reg;
  logic        zero_hit_reg;
  logic [1:0]  sel;
  logic        force_zero;
  logic        zero_det_en;
  logic [7:0]  right_level;

  dscp_sync #(
    .WIDTH(7)
  ) u_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in ({link.mode_sel_pin, link.reset_n_pin, link.control_clock_pin,
                link.control_latch_pin, link.control_data_pin, bit_clock_in,
                frame_clock_in}),
    .sync_out (pins_s)
  );

  // Audio data has the same synchroniser depth as the bit clock.
  // Both therefore stay aligned when a bit clock edge is sampled.
  dscp_sync #(
    .WIDTH(1)
  ) u_sync_din (
    .clk      (clk),
    .reset    (reset),
    .async_in (audio_data_in),
    .sync_out (din_s)
  );

  assign {mode_s, rstn_s, mclk_s, latch_s, data_s, bck_s, lrc_s} = pins_s;

  assign port_en    = mode_s & rstn_s;
  assign mclk_rise  = mclk_s & ~mclk_q_reg;
  assign latch_fall = latch_q_reg & ~latch_s;
  assign bck_rise   = bck_s & ~bck_q_reg;
  assign sel        = {shift_reg[dscp_pkg::SEL_HI_BIT],
                       shift_reg[dscp_pkg::SEL_LO_BIT]};
  assign force_zero  = mute_ctl_reg[dscp_pkg::FORCE_ZERO_BIT];
  assign zero_det_en = mute_ctl_reg[dscp_pkg::ZERO_DET_BIT];
  assign right_level = format_ctl_reg[dscp_pkg::SHARED_BIT]
                       ? left_applied_reg : right_applied_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      mclk_q_reg  <= 1'b0;
      latch_q_reg <= 1'b0;
      bck_q_reg   <= 1'b0;
    end else begin
      mclk_q_reg  <= mclk_s;
      latch_q_reg <= latch_s;
      bck_q_reg   <= bck_s;
    end
  end

  // Bits enter MSB first, one per rising control clock edge.
  always_ff @(posedge clk) begin
    if (reset || !port_en) begin
      shift_reg <= '0;
    end else if (mclk_rise) begin
      shift_reg <= {shift_reg[14:0], data_s};
    end
  end

  // A low reset pin returns every mode control to its default.
  always_ff @(posedge clk) begin
    if (reset || !rstn_s) begin
      left_ctl_reg   <= dscp_pkg::RST_LEFT;
      right_ctl_reg  <= dscp_pkg::RST_RIGHT;
      mute_ctl_reg   <= dscp_pkg::RST_MUTE;
      format_ctl_reg <= dscp_pkg::RST_FORMAT;
    end else if (port_en && latch_fall) begin
      case (sel)
        2'h0:    left_ctl_reg   <= shift_reg;
        2'h1:    right_ctl_reg  <= shift_reg;
        2'h2:    mute_ctl_reg   <= shift_reg;
        2'h3:    format_ctl_reg <= shift_reg;
        default: left_ctl_reg   <= left_ctl_reg;
      endcase
    end
  end

  // The applied level follows the stored word only while its commit bit
  // is set, so a deferred word leaves the output at its old level.
  always_ff @(posedge clk) begin
    if (reset || !rstn_s) begin
      left_applied_reg  <= dscp_pkg::RST_LEFT[7:0];
      right_applied_reg <= dscp_pkg::RST_RIGHT[7:0];
    end else begin
      if (left_ctl_reg[dscp_pkg::COMMIT_BIT]) begin
        left_applied_reg <= left_ctl_reg[7:0];
      end
      if (right_ctl_reg[dscp_pkg::COMMIT_BIT]) begin
        right_applied_reg <= right_ctl_reg[7:0];
      end
    end
  end

  // Any one bit sampled on the bit clock ends a zero run at once.
  always_ff @(posedge clk) begin
    if (reset || !rstn_s || !zero_det_en) begin
      zero_cnt_reg <= '0;
      zero_hit_reg <= 1'b0;
    end else if (bck_rise) begin
      if (din_s) begin
        zero_cnt_reg <= '0;
        zero_hit_reg <= 1'b0;
      end else if (zero_cnt_reg == 17'(ZERO_RUN - 1)) begin
        zero_hit_reg <= 1'b1;
      end else begin
        zero_cnt_reg <= zero_cnt_reg + 17'h0_0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bipolar_zero        <= 1'b1;
      modulator_connected <= 1'b0;
    end else begin
      bipolar_zero        <= ~rstn_s | force_zero
                             | (zero_det_en & zero_hit_reg);
      modulator_connected <= rstn_s & ~force_zero
                             & ~(zero_det_en & zero_hit_reg);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      left_gain_y       <= dscp_pkg::GAIN_UNITY;
      right_gain_y      <= dscp_pkg::GAIN_UNITY;
      soft_mute         <= 1'b0;
      deemph_sel        <= 2'h0;
      i2s_format_sel    <= 1'b0;
      word_length_sel   <= 1'b0;
      left_frame_active <= 1'b0;
      left_route        <= 2'h2;
      right_route       <= 2'h2;
    end else begin
      left_gain_y       <= gain_y(left_applied_reg);
      right_gain_y      <= gain_y(right_level);
      soft_mute         <= mute_ctl_reg[dscp_pkg::MUTE_BIT];
      deemph_sel        <=
        {mute_ctl_reg[dscp_pkg::DEEMPH_HI_BIT],
         mute_ctl_reg[dscp_pkg::DEEMPH_LO_BIT]};
      i2s_format_sel    <= format_ctl_reg[dscp_pkg::I2S_BIT];
      word_length_sel   <= format_ctl_reg[dscp_pkg::WORD_LEN_BIT];
      left_frame_active <=
        lrc_s ^ format_ctl_reg[dscp_pkg::LR_POL_BIT];
      left_route        <=
        {format_ctl_reg[dscp_pkg::ROUTE_LSB],
         format_ctl_reg[dscp_pkg::ROUTE_LSB + 1]};
      right_route       <=
        {format_ctl_reg[dscp_pkg::ROUTE_LSB + 2],
         format_ctl_reg[dscp_pkg::ROUTE_LSB + 3]};
    end
  end
endmodule : dscp_dev
`default_nettype wire

// >>> include/dscp_pkg.sv
// Constants shared by both ends of the three-wire DAC control port.
// Assumes a 250 MHz system clock on both ends of the link.
// What this block does
// - High mode pin selects three-wire serial control.
// - Sixteen-bit words; bits 9,10 pick register.
// - Host clocks bits; device samples on control clock.
// - Latch low transfers shifted word into register.
// - Host writes zero into every reserved bit.
// - Left level code gives gain y/256, 255->256.
// - Left level applies only when commit bit set.
// - Register 1 does same for right channel.
// - Register 2 bit 0 soft-mutes the output.
// - Register 2 bits 1,2 select de-emphasis rate.
// - Force-zero bit holds both outputs at bipolar zero.
// - Enabled detector forces zero after 65536 zero bits.
// - Detector disabled: zeros convert normally, stay connected.
// - Reset pin low: bipolar zero, serial input disabled.
// - Register 3 bit 0 selects I2S or right-justified.
// - Polarity bit swaps which frame level is left.
// - Register 3 bit 2 picks 16 or 18 bits.
// - Shared bit makes both channels use left attenuation.
// - Register 3 bits 4-7 route each output channel.
// - Reset values 0x00FF, 0x02FF, 0x0400, 0x0690.
// - Host waits 1024 clocks before programming takes effect.
package dscp_pkg;

  localparam int WORD_BITS = 16;
  localparam int SEL_LO_BIT = 9;
  localparam int SEL_HI_BIT = 10;
  localparam int COMMIT_BIT = 8;
  localparam int MUTE_BIT = 0;
  localparam int DEEMPH_LO_BIT = 1;
  localparam int DEEMPH_HI_BIT = 2;
  localparam int FORCE_ZERO_BIT = 3;
  localparam int ZERO_DET_BIT = 4;
  localparam int I2S_BIT = 0;
  localparam int LR_POL_BIT = 1;
  localparam int WORD_LEN_BIT = 2;
  localparam int SHARED_BIT = 3;
  localparam int ROUTE_LSB = 4;

  localparam logic [15:0] RST_LEFT = 16'h00FF;
  localparam logic [15:0] RST_RIGHT = 16'h02FF;
  localparam logic [15:0] RST_MUTE = 16'h0400;
  localparam logic [15:0] RST_FORMAT = 16'h0690;

  // Writable bits of each register, the select bits included.
  localparam logic [15:0] MASK_ATTEN = 16'h07FF;
  localparam logic [15:0] MASK_MUTE = 16'h061F;
  localparam logic [15:0] MASK_FORMAT = 16'h06FF;

  localparam logic [7:0] LEVEL_FULL = 8'hFF;
  localparam logic [8:0] GAIN_UNITY = 9'h100;

  localparam int ZERO_RUN_BCK = 65536;
  localparam int INIT_CYCLES = 1024;
  localparam int HALF_BIT_CYCLES = 10;

  localparam logic [3:0] OFS_WORD = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_PINS = 4'h8;
  localparam logic [1:0] RST_PINS = 2'h3;

  typedef enum logic [1:0] {
    DSCP_IDLE = 2'b00,
    DSCP_LOW = 2'b01,
    DSCP_HIGH = 2'b11,
    DSCP_LATCH = 2'b10
  } dscp_state_e;

endpackage : dscp_pkg

// >>> include/dscp_if.sv
// Pins of the three-wire control port between host and converter.
// Assumes the bench joins one host end and one device end to it.
`timescale 1ns/10ps
`default_nettype none
interface dscp_if;
  logic control_clock_pin;
  logic control_latch_pin;
  logic control_data_pin;
  logic mode_sel_pin;
  logic reset_n_pin;

  modport host (
    output control_clock_pin,
    output control_latch_pin,
    output control_data_pin,
    output mode_sel_pin,
    output reset_n_pin
  );

  modport dev (
    input control_clock_pin,
    input control_latch_pin,
    input control_data_pin,
    input mode_sel_pin,
    input reset_n_pin
  );
endinterface : dscp_if
`default_nettype wire

// >>> rtl/dscp_sync.sv
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level or a clock far below clk.
`timescale 1ns/10ps
`default_nettype none
module dscp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : dscp_sync
`default_nettype wire

// >>> rtl/dscp_host.sv
// Host end: takes words over a plain register port and shifts them out.
// Assumes the device samples the pins with a clock of similar speed.
`timescale 1ns/10ps
`default_nettype none
module dscp_host #(
  parameter int HALF_BIT = dscp_pkg::HALF_BIT_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset,
  dscp_if.host             link,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wr_data,
  input  wire logic        wr_strobe,
  input  wire logic        rd_strobe,
  output logic      [15:0] rd_data
);

  // Reserved bits are cleared so the device never sees them set.
  function automatic logic [15:0] clean_word(input logic [15:0] w);
    case ({w[dscp_pkg::SEL_HI_BIT], w[dscp_pkg::SEL_LO_BIT]})
      2'h2:    clean_word = w & dscp_pkg::MASK_MUTE;
      2'h3:    clean_word = w & dscp_pkg::MASK_FORMAT;
      default: clean_word = w & dscp_pkg::MASK_ATTEN;
    endcase
  endfunction : clean_word

  dscp_pkg::dscp_state_e state_reg;
  logic [15:0] word_reg;
  logic [15:0] last_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  timer_reg;
  logic [10:0] init_cnt_reg;
  logic [1:0]  pins_reg;
  logic        ready;
  logic        busy;
  logic        tick;
  logic        start;

  assign ready = init_cnt_reg == 11'(dscp_pkg::INIT_CYCLES);
  assign busy  = state_reg != dscp_pkg::DSCP_IDLE;
  assign tick  = timer_reg == 8'(HALF_BIT - 1);
  assign start = wr_strobe && addr == dscp_pkg::OFS_WORD && !busy && ready;

  always_ff @(posedge clk) begin
    if (reset) begin
      pins_reg <= dscp_pkg::RST_PINS;
    end else if (wr_strobe && addr == dscp_pkg::OFS_PINS) begin
      pins_reg <= wr_data[1:0];
    end
  end

  // No word starts until 1024 clocks have passed with the reset pin high.
  always_ff @(posedge clk) begin
    if (reset || !pins_reg[0]) begin
      init_cnt_reg <= '0;
    end else if (!ready) begin
      init_cnt_reg <= init_cnt_reg + 11'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || state_reg == dscp_pkg::DSCP_IDLE || tick) begin
      timer_reg <= '0;
    end else begin
      timer_reg <= timer_reg + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg   <= dscp_pkg::DSCP_IDLE;
      word_reg    <= '0;
      last_reg    <= '0;
      bit_cnt_reg <= '0;
    end else begin
      case (state_reg)
        dscp_pkg::DSCP_IDLE: begin
          if (start) begin
            word_reg    <= clean_word(wr_data);
            last_reg    <= clean_word(wr_data);
            bit_cnt_reg <= 4'hF;
            state_reg   <= dscp_pkg::DSCP_LOW;
          end
        end
        dscp_pkg::DSCP_LOW: begin
          if (tick) begin
            state_reg <= dscp_pkg::DSCP_HIGH;
          end
        end
        dscp_pkg::DSCP_HIGH: begin
          if (tick) begin
            word_reg    <= {word_reg[14:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg - 4'h1;
            state_reg   <= (bit_cnt_reg == 4'h0) ? dscp_pkg::DSCP_LATCH
                                                 : dscp_pkg::DSCP_LOW;
          end
        end
        dscp_pkg::DSCP_LATCH: begin
          if (tick) begin
            state_reg <= dscp_pkg::DSCP_IDLE;
          end
        end
        default: state_reg <= dscp_pkg::DSCP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      link.control_clock_pin <= 1'b0;
      link.control_latch_pin <= 1'b1;
      link.control_data_pin  <= 1'b0;
      link.mode_sel_pin      <= 1'b1;
      link.reset_n_pin       <= 1'b1;
    end else begin
      link.control_clock_pin <= state_reg == dscp_pkg::DSCP_HIGH;
      link.control_latch_pin <= state_reg != dscp_pkg::DSCP_LATCH;
      link.control_data_pin  <= word_reg[15];
      link.mode_sel_pin      <= pins_reg[1];
      link.reset_n_pin       <= pins_reg[0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data <= '0;
    end else if (rd_strobe) begin
      case (addr)
        dscp_pkg::OFS_WORD:   rd_data <= last_reg;
        dscp_pkg::OFS_STATUS: rd_data <= {14'h0000, ready, busy};
        dscp_pkg::OFS_PINS:   rd_data <= {14'h0000, pins_reg};
        default:              rd_data <= '0;
      endcase
    end else begin
      rd_data <= '0;
    end
  end
endmodule : dscp_host
`default_nettype wire

// >>> dv/dscp_props.sv
// Checker on the three-wire control port pins between host and device.
// Assumes it watches the one interface that joins both design ends.
`timescale 1ns/10ps
`default_nettype none
module dscp_props #(
  parameter int HALF = 10
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic control_clock_pin,
  input wire logic control_latch_pin,
  input wire logic control_data_pin,
  input wire logic mode_sel_pin,
  input wire logic reset_n_pin
);
  logic [15:0] hi_cnt;
  logic [15:0] lo_cnt;
  logic [15:0] lat_cnt;
  logic [15:0] rise_cnt;
  logic [11:0] init_cnt;
  logic        ck_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // Phase lengths are counted here because a repetition cannot reach them.
  always_ff @(posedge clk) begin
    ck_q    <= control_clock_pin;
    hi_cnt  <= (reset || !control_clock_pin) ? 16'h0 : hi_cnt + 16'h1;
    lo_cnt  <= (reset || control_clock_pin) ? 16'h0 : lo_cnt + 16'h1;
    lat_cnt <= (reset || control_latch_pin) ? 16'h0 : lat_cnt + 16'h1;
    if (reset || !control_latch_pin) begin
      rise_cnt <= 16'h0;
    end else if (control_clock_pin && !ck_q) begin
      rise_cnt <= rise_cnt + 16'h1;
    end
    if (reset || !reset_n_pin) begin
      init_cnt <= 12'h0;
    end else if (init_cnt < 12'h800) begin
      init_cnt <= init_cnt + 12'h1;
    end
  end

  data_stable_high_a: assert property (
    control_clock_pin && ck_q |-> $stable(control_data_pin))
    else $error("Data moved while the control clock was high.");
  clk_high_len_a: assert property (
    $fell(control_clock_pin) |-> hi_cnt == HALF)
    else $error("Control clock high phase has the wrong length.");
  clk_low_len_a: assert property (
    $rose(control_clock_pin) && rise_cnt != 0 |-> lo_cnt == HALF)
    else $error("Control clock low phase has the wrong length.");
  latch_low_len_a: assert property (
    $rose(control_latch_pin) |-> lat_cnt == HALF)
    else $error("Latch low pulse has the wrong length.");
  bits_per_word_a: assert property (
    $fell(control_latch_pin) |-> rise_cnt == 16)
    else $error("Latch fell after a word of the wrong length.");
  no_clk_latch_a: assert property (
    !control_latch_pin |-> !$rose(control_clock_pin))
    else $error("Control clock rose while the latch was low.");
  init_wait_a: assert property (
    $rose(control_clock_pin) |-> init_cnt >= 12'h400)
    else $error("Word shifted before the start-up wait ended.");
  latch_in_reset_a: assert property (
    !control_latch_pin |-> reset_n_pin && $stable(mode_sel_pin))
    else $error("Latch pulse while the device was held in reset.");
endmodule : dscp_props
`default_nettype wire

// >>> dv/test_dac_serial_control_port.sv
// Testbench: host end and device end joined by the control port.
// Assumes one 250 MHz clock and a synchronous reset for both ends.
`timescale 1ns/10ps
`default_nettype none
module test_dac_serial_control_port;
  // A short zero run keeps the detector test brief.
  localparam int ZRUN = 16;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wr_data = 16'h0000;
  logic        wr_strobe = 1'b0;
  logic        rd_strobe = 1'b0;
  logic [15:0] rd_data;
  logic        bck = 1'b0;
  logic        frame = 1'b1;
  logic        audio = 1'b1;
  logic [8:0]  lg, rg;
  logic [1:0]  dm, lr, rr;
  logic        sm, bz, mod_on, i2s, wl, lfa;
  int          failures = 0;
  int          compares = 0;
  logic [15:0] d;
  logic [7:0]  lv [4] = '{8'hFF, 8'hFE, 8'h00, 8'h01};
  logic [3:0]  r;

  dscp_if ifc ();
  dscp_host i_dscp_host (.clk(clk), .reset(reset), .link(ifc.host),
    .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rd_data(rd_data));
  dscp_dev #(.ZERO_RUN(ZRUN)) i_dscp_dev (.clk(clk), .reset(reset),
    .link(ifc.dev), .bit_clock_in(bck), .frame_clock_in(frame),
    .audio_data_in(audio), .left_gain_y(lg), .right_gain_y(rg),
    .soft_mute(sm), .deemph_sel(dm), .bipolar_zero(bz),
    .modulator_connected(mod_on), .i2s_format_sel(i2s),
    .word_length_sel(wl), .left_frame_active(lfa),
    .left_route(lr), .right_route(rr));
  dscp_props #(.HALF(dscp_pkg::HALF_BIT_CYCLES)) i_dscp_props (
    .clk(clk), .reset(reset),
    .control_clock_pin(ifc.control_clock_pin),
    .control_latch_pin(ifc.control_latch_pin),
    .control_data_pin(ifc.control_data_pin),
    .mode_sel_pin(ifc.mode_sel_pin), .reset_n_pin(ifc.reset_n_pin));

  always #2 clk = ~clk;
  // The bit clock is offset so its edges never line up with clk.
  initial begin
    #7;
    forever #40 bck = ~bck;
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1 v = rd_data;
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wr_data <= v;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
  endtask : wr

  // Polls status until ready and not busy, bounded against a hang.
  task automatic wait_idle();
    int n;
    logic [15:0] s;
    n = 0;
    s = 16'h0000;
    while (s[1:0] !== 2'b10 && n < 1500) begin
      rd(4'h4, s);
      n++;
    end
    check("status", {14'h0, s[1:0]}, 16'h0002);
  endtask : wait_idle

  task automatic send(input logic [15:0] w);
    wait_idle();
    wr(4'h0, w);
    wait_idle();
    repeat (6) @(posedge clk);
  endtask : send

  task automatic bits(input int n);
    repeat (n * 20) @(posedge clk);
  endtask : bits

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // The tests need about 17,000 cycles; 50,000 leaves ample margin.
  initial begin
    #200000;
    failures++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(4'h8, d);
    check("pins", d, 16'h0003);
    check("latch", {15'h0, ifc.control_latch_pin}, 16'h0001);
    wait_idle();
    check("left gain", 16'(lg), 16'h0100);
    check("right gain", 16'(rg), 16'h0100);
    check("mute", {14'h0, sm, bz}, 16'h0000);
    check("deemph", 16'(dm), 16'h0000);
    check("format", {13'h0, i2s, wl, lfa}, 16'h0001);
    check("routes", {12'h0, lr, rr}, 16'h0009);
    $display("Test reset values done");
    foreach (lv[i]) begin
      send({8'h01, lv[i]});
      check("left gain", 16'(lg),
            (lv[i] == 8'hFF) ? 16'h0100 : {8'h00, lv[i]});
    end
    send(16'h0033);
    check("deferred", 16'(lg), 16'h0001);
    send(16'h0133);
    check("commit", 16'(lg), 16'h0033);
    send(16'h0280);
    check("right defer", 16'(rg), 16'h0100);
    send(16'h0380);
    check("right commit", 16'(rg), 16'h0080);
    check("left kept", 16'(lg), 16'h0033);
    $display("Test attenuation done");
    for (int i = 0; i < 8; i++) begin
      send(16'h0400 | 16'(i));
      check("mute", {15'h0, sm}, 16'(i[0]));
      check("deemph", 16'(dm), 16'({i[2], i[1]}));
    end
    send(16'h0408);
    check("force zero", {14'h0, bz, mod_on}, 16'h0002);
    send(16'h0400);
    check("released", {14'h0, bz, mod_on}, 16'h0001);
    $display("Test mute and output done");
    for (int i = 0; i < 16; i++) begin
      r = 4'(i);
      frame <= r[2];
      send({8'h06, r, r});
      check("i2s", {15'h0, i2s}, {15'h0, r[0]});
      check("frame", {15'h0, lfa}, {15'h0, r[2] ^ r[1]});
      check("length", {15'h0, wl}, {15'h0, r[2]});
      check("shared", 16'(rg), r[3] ? 16'h0033 : 16'h0080);
      check("routes", {12'h0, lr, rr},
            {12'h0, r[0], r[1], r[2], r[3]});
    end
    send(16'hFFFF);
    rd(4'h0, d);
    check("cleaned word", d, 16'h06FF);
    $display("Test format and routing done");
    send(16'h0410);
    @(posedge clk);
    audio <= 1'b0;
    bits(12);
    check("short run", {15'h0, bz}, 16'h0000);
    bits(8);
    check("long run", {14'h0, bz, mod_on}, 16'h0002);
    audio <= 1'b1;
    bits(3);
    check("resume", {15'h0, bz}, 16'h0000);
    audio <= 1'b0;
    bits(12);
    check("restart", {15'h0, bz}, 16'h0000);
    audio <= 1'b1;
    send(16'h0400);
    audio <= 1'b0;
    bits(20);
    check("detector off", {14'h0, bz, mod_on}, 16'h0001);
    audio <= 1'b1;
    $display("Test zero detection done");
    wr(4'h8, 16'h0002);
    repeat (10) @(posedge clk);
    check("pin reset", {15'h0, bz}, 16'h0001);
    wr(4'h8, 16'h0003);
    wait_idle();
    check("regs reset", 16'(lg), 16'h0100);
    wr(4'h8, 16'h0001);
    send(16'h0155);
    check("mode low", 16'(lg), 16'h0100);
    wr(4'h8, 16'h0003);
    send(16'h0155);
    check("mode high", 16'(lg), 16'h0055);
    rd(4'hC, d);
    check("unmapped", d, 16'h0000);
    $display("Test pins and mode done");
    report_and_stop();
  end
endmodule : test_dac_serial_control_port
`default_nettype wire
